// File: dv/tsd_far_model.sv
// Far side model: external DMA controller and switch memories.
// Assumes one core clock; grant follows request, memory answers late.
`timescale 1ns/1ns
module tsd_far_model
	import tsd_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// DMA side
	input wire logic [1:0] req_n,
	input wire logic [1:0] g_en,
	input wire logic [7:0] ad_out,
	output logic [1:0] grant_n = 2'h3,
	output logic [7:0] dma_wd = 8'h50,
	// Memory side
	input tsd_mem_req_t mem_o,
	output logic [7:0] mem_rdata = 8'h00,
	output logic mem_done = 1'b0
);
	logic [7:0] m [0:3][0:511];
	logic [7:0] rx [0:31];
	int nrx = 0;
	logic [1:0] beat_q = 2'h0;
	logic [2:0] mc = 3'h0;
	logic [7:0] tk = 8'h00;
	////////////////////////////////////////////////////////////////////
	// Grant while requested, collect read beats
	always @(posedge core_clk)
	begin
		beat_q <= ~grant_n & ~req_n;
		if (beat_q[1])
		begin
			rx[nrx[4:0]] <= ad_out;
			nrx <= nrx + 1;
		end
		if (srst)
			dma_wd <= 8'h50;
		else if (!grant_n[0] && !req_n[0])
			dma_wd <= dma_wd + 8'h01;
		grant_n <= ~(~req_n & g_en & {2{!srst}});
	end
	////////////////////////////////////////////////////////////////////
	// Memory completes after a wait
	always @(posedge core_clk)
	begin
		tk <= tk + 8'h3B;
		mem_rdata <= ~tk;
		mem_done <= 1'b0;
		if (mem_done || !mem_o.req)
			mc <= 3'h0;
		else if (mc == 3'h3)
		begin
			mem_done <= 1'b1;
			mc <= 3'h0;
			if (mem_o.we)
				m[mem_o.space][mem_o.addr] <= mem_o.wdata;
			else
				mem_rdata <= m[mem_o.space][mem_o.addr];
		end
		else
			mc <= mc + 3'h1;
	end
endmodule // tsd_far_model

// File: dv/tsd_host_dma_bench.sv
// Bench of the host registers and DMA engine.
// Assumes the far model answers grants and memory accesses.
`timescale 1ns/1ns
module tsd_host_dma_bench
	import tsd_pkg::*;
;
	logic core_clk = 1'b0;
	logic srst = 1'b1;
	logic hp_cs_n = 1'b1;
	logic hp_rd_n = 1'b1;
	logic hp_wr_n = 1'b1;
	logic hp_ale = 1'b0;
	logic [1:0] hp_addr = 2'h0;
	logic [7:0] ad_drv = 8'h00;
	logic [7:0] hp_ad_in, hp_ad_out, mem_rdata, dma_wd, d;
	logic hp_ad_oe, hp_rdy, mem_done, dma_active, err_pin, w;
	tsd_mem_req_t mem_o;
	tsd_ts_t ts_i = '0;
	tsd_wr_out_t wr_o, wr_cap;
	logic [1:0] req_n, grant_n;
	logic [1:0] g_en = 2'h3;
	logic pll_unlock = 1'b0;
	logic bp_clk = 1'b0;
	logic bp_run = 1'b1;
	logic bus_timing_master, stream_drive_enable, bp_out_oe, bp_clk_oe;
	logic local_serial_out_even, local_serial_out_odd;
	logic [CTRL_N-1:0][7:0] cfg_o;
	int n_errors = 0;
	int checked = 0;
	int cyc = 0;
	int n0;
	assign hp_ad_in = grant_n[0] ? ad_drv : dma_wd;
	////////////////////////////////////////////////////////////////////
	tsd_host_dma #(.DEAD_CYC(50)) DUT (.core_clk(core_clk), .srst(srst),
		.hp_cs_n(hp_cs_n), .hp_rd_n(hp_rd_n), .hp_wr_n(hp_wr_n),
		.hp_ale(hp_ale), // Strobe mode first
		.hp_addr(hp_addr), .hp_ad_in(hp_ad_in), .hp_ad_out(hp_ad_out),
		.hp_ad_oe(hp_ad_oe), .hp_rdy(hp_rdy), .mem_o(mem_o),
		.mem_rdata(mem_rdata), .mem_done(mem_done), .ts_i(ts_i),
		.rd_bytes(32'h44332211), .wr_o(wr_o), .dma_active(dma_active),
		.xfer_request_line_n(req_n), .xfer_grant_line_n(grant_n),
		.pll_unlock(pll_unlock), .backplane_4mhz_clock(bp_clk),
		.ls_even_in(1'b0), .ls_odd_in(1'b1), .err_pin(err_pin),
		.bus_timing_master(bus_timing_master),
		.stream_drive_enable(stream_drive_enable), .bp_out_oe(bp_out_oe),
		.bp_clk_oe(bp_clk_oe), .local_serial_out_even(local_serial_out_even),
		.local_serial_out_odd(local_serial_out_odd), .cfg_o(cfg_o));
	tsd_far_model P (.core_clk(core_clk), .srst(srst), .req_n(req_n),
		.g_en(g_en), .ad_out(hp_ad_out), .grant_n(grant_n), .dma_wd(dma_wd),
		.mem_o(mem_o), .mem_rdata(mem_rdata), .mem_done(mem_done));
	////////////////////////////////////////////////////////////////////
	initial
		forever #25 core_clk = ~core_clk;
	always @(posedge core_clk)
	begin
		if (bp_run)
			bp_clk <= ~bp_clk;
		if (wr_o.valid)
			wr_cap <= wr_o;
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			n_errors = n_errors + 1;
			report_and_stop;
		end
	end
	////////////////////////////////////////////////////////////////////
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		checked++;
		if (s !== e)
		begin
			n_errors++;
			$display("CHECK FAILED t=%0t seen %h exp %h", $time, s, e);
		end
	endtask
	task automatic chb(input logic s, input logic e);
		chk({7'h0, s}, {7'h0, e});
	endtask
	task automatic acc(input logic [1:0] a, input logic we,
		input logic [7:0] v);
		int k;
		@(posedge core_clk);
		hp_cs_n <= 1'b0;
		hp_rd_n <= we;
		hp_wr_n <= !we;
		hp_addr <= a;
		ad_drv <= v;
		repeat (2) @(posedge core_clk);
		w = 1'b0;
		for (k = 0; k < 40 && hp_rdy !== 1'b1; k++)
		begin
			w = 1'b1;
			@(posedge core_clk);
		end
		d = hp_ad_out;
		hp_cs_n <= 1'b1;
		hp_rd_n <= 1'b1;
		hp_wr_n <= 1'b1;
	endtask
	task automatic wr(input logic [1:0] a, input logic [7:0] v);
		acc(a, 1'b1, v);
	endtask
	task automatic rd(input logic [1:0] a);
		acc(a, 1'b0, 8'h00);
	endtask
	task automatic slot(input int k, input logic [4:0] ix,
		input logic [2:0] n);
		@(posedge core_clk);
		ts_i <= {3'b100 >> k, ix, n != 3'h0, n};
		@(posedge core_clk);
		ts_i <= {3'h0, ts_i[8:0]};
	endtask
	task automatic wait_req(input int b, input logic v);
		int k;
		for (k = 0; k < 60 && req_n[b] !== v; k++)
			@(posedge core_clk);
		chb(req_n[b], v);
	endtask
	////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		rd(REG_MCS);
		chk(d, REG_RST);
		chb(w, 1'b0);
		rd(REG_AMR);
		chk(d, REG_RST);
		chb(local_serial_out_even, 1'b1);
		chb(local_serial_out_odd, 1'b0);
		chb(bp_out_oe, 1'b0);
		chb(stream_drive_enable, 1'b0);
		$display("test reset done");
	endtask
	task automatic t_outputs;
		wr(REG_MCS, 8'h0A);
		repeat (2) @(posedge core_clk);
		chb(bus_timing_master, 1'b1);
		chb(bp_clk_oe, 1'b1);
		chb(bp_out_oe, 1'b1);
		chb(local_serial_out_odd, 1'b1);
		chb(local_serial_out_even, 1'b0);
		wr(REG_MCS, 8'h02);
		repeat (2) @(posedge core_clk);
		chb(bp_clk_oe, 1'b0);
		chb(bus_timing_master, 1'b0);
		$display("test outputs done");
	endtask
	task automatic t_window;
		wr(REG_LAR, 8'h05);
		wr(REG_AMR, 8'h91);
		wr(REG_IDR, 8'h11);
		chb(w, 1'b1);
		wr(REG_IDR, 8'h22);
		chk(P.m[1][9'h105], 8'h11);
		chk(P.m[1][9'h106], 8'h22);
		wr(REG_AMR, 8'h51);
		wr(REG_LAR, 8'h05);
		rd(REG_IDR);
		chk(d, 8'h11);
		rd(REG_IDR);
		chk(d, 8'h22);
		wr(REG_LAR, 8'h20);
		wr(REG_AMR, 8'h10);
		wr(REG_IDR, 8'h01);
		wr(REG_IDR, 8'h02);
		chk(P.m[1][9'h020], 8'h02);
		wr(REG_LAR, 8'h10);
		wr(REG_AMR, 8'hA0);
		wr(REG_IDR, 8'hC1);
		wr(REG_IDR, 8'hC2);
		wr(REG_IDR, 8'hC3);
		chk(P.m[2][9'h010], 8'hC1);
		chk(P.m[3][9'h010], 8'hC2);
		chk(P.m[2][9'h011], 8'hC3);
		$display("test window done");
	endtask
	task automatic t_soft;
		wr(REG_AMR, 8'h00);
		wr(REG_LAR, 8'h02);
		wr(REG_IDR, 8'h77);
		chk(cfg_o[2], 8'h77);
		wr(REG_LAR, 8'h5A);
		wr(REG_MCS, 8'h03);
		wr(REG_MCS, 8'h00);
		rd(REG_LAR);
		chk(d, 8'h00);
		chk(cfg_o[2], 8'h00);
		$display("test soft reset done");
	endtask
	task automatic t_dma_rd;
		wr(REG_MCS, 8'h06); // Gate set before slots carry marks
		slot(1, 5'h01, 3'h2);
		repeat (8) @(posedge core_clk);
		chk({6'h0, req_n}, 8'h03);
		slot(0, 5'h00, 3'h0);
		slot(1, 5'h00, 3'h1);
		repeat (8) @(posedge core_clk);
		chk({6'h0, req_n}, 8'h03);
		n0 = P.nrx;
		slot(1, 5'h01, 3'h2);
		wait_req(1, 1'b0);
		chb(req_n[0], 1'b1);
		wait_req(1, 1'b1);
		repeat (2) @(posedge core_clk);
		chk(8'(P.nrx - n0), 8'h02);
		chk(P.rx[n0], 8'h11);
		chk(P.rx[n0 + 1], 8'h22);
		n0 = P.nrx;
		slot(1, 5'h02, 3'h6);
		wait_req(1, 1'b0);
		wait_req(1, 1'b1);
		repeat (2) @(posedge core_clk);
		chk(8'(P.nrx - n0), 8'h04);
		$display("test dma read done");
	endtask
	task automatic t_dma_wr;
		slot(2, 5'h01, 3'h2);
		wait_req(0, 1'b0);
		chb(req_n[1], 1'b1);
		wait_req(0, 1'b1);
		slot(2, 5'h02, 3'h1);
		repeat (3) @(posedge core_clk);
		chk({3'h0, wr_cap.ts}, 8'h02);
		chk({5'h0, wr_cap.cnt}, 8'h02);
		chk(wr_cap.bytes[0], 8'h50);
		chk(wr_cap.bytes[1], 8'h51);
		wait_req(0, 1'b1);
		$display("test dma write done");
	endtask
	task automatic t_overrun;
		g_en <= 2'h1;
		slot(1, 5'h03, 3'h1);
		repeat (4) @(posedge core_clk);
		slot(1, 5'h04, 3'h1);
		repeat (4) @(posedge core_clk);
		chb(err_pin, 1'b1);
		g_en <= 2'h3;
		wait_req(1, 1'b1);
		rd(REG_MCS);
		chk(d & MCS_STICKY, 8'h20);
		wr(REG_MCS, 8'hF6);
		rd(REG_MCS);
		chk(d, 8'h26);
		chb(err_pin, 1'b1);
		wr(REG_MCS, 8'h06);
		rd(REG_MCS);
		chk(d, 8'h06);
		chb(err_pin, 1'b0);
		$display("test overrun done");
	endtask
	task automatic t_status;
		@(posedge core_clk);
		pll_unlock <= 1'b1;
		@(posedge core_clk);
		pll_unlock <= 1'b0;
		rd(REG_MCS);
		chk(d, 8'h86);
		chb(err_pin, 1'b1);
		wr(REG_MCS, 8'h06);
		rd(REG_MCS);
		chk(d, 8'h06);
		bp_run <= 1'b0;
		repeat (40) @(posedge core_clk);
		rd(REG_MCS);
		chk(d, 8'h06);
		repeat (20) @(posedge core_clk);
		rd(REG_MCS);
		chk(d, 8'h16);
		chb(err_pin, 1'b1);
		$display("test status done");
	endtask
	task automatic t_dsrw;
		hp_ale <= 1'b1;
		srst <= 1'b1;
		repeat (2) @(posedge core_clk);
		srst <= 1'b0;
		repeat (2) @(posedge core_clk);
		chb(err_pin, 1'b0);
		hp_cs_n <= 1'b0;
		hp_rd_n <= 1'b0;
		hp_wr_n <= 1'b0;
		hp_addr <= REG_MCS;
		ad_drv <= 8'h06;
		repeat (2) @(posedge core_clk);
		hp_cs_n <= 1'b1;
		hp_rd_n <= 1'b1;
		hp_wr_n <= 1'b1;
		slot(0, 5'h00, 3'h0);
		slot(1, 5'h01, 3'h1);
		repeat (4) @(posedge core_clk);
		chb(stream_drive_enable, 1'b1);
		chb(dma_active, 1'b0);
		chk({6'h0, req_n}, 8'h03);
		$display("test bus style done");
	endtask
	////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (8) @(posedge core_clk);
		srst <= 1'b0;
		t_reset;
		t_outputs;
		t_window;
		t_soft;
		t_dma_rd;
		t_dma_wr;
		t_overrun;
		t_status;
		t_dsrw;
		report_and_stop;
	end
endmodule // tsd_host_dma_bench

// File: src/tsd_clk_mon.sv
// Activity watchdog on the backplane 4 MHz clock input.
// Assumes the clock pin is sampled as a synchronous input.
`timescale 1ns/1ns
module tsd_clk_mon
	import tsd_pkg::*;
#(
	parameter int DEAD_CYC = BP_DEAD_CYC
)
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// Watched pin and result
	input wire logic clk_in,
	output logic dead
);
	localparam int CW = $clog2(DEAD_CYC + 1);
	localparam logic [CW-1:0] LAST = CW'(DEAD_CYC - 1);
	typedef struct packed {
		logic prev;
		logic [CW-1:0] cnt;
		logic dead;
	} tsd_mon_q_t;
	tsd_mon_q_t st_q, st_d;
	assign dead = st_q.dead;
	always_comb
	begin
		st_d = st_q;
		st_d.prev = clk_in;
		st_d.dead = 1'b0;
		if (clk_in != st_q.prev)
			st_d.cnt = '0;
		else if (st_q.cnt == LAST) // [RULE14]
		begin
			st_d.cnt = '0;
			st_d.dead = 1'b1;
		end
		else
			st_d.cnt = st_q.cnt + CW'(1);
	end
	always_ff @(posedge core_clk)
	begin
		if (srst)
			st_q <= '0;
		else
			st_q <= st_d;
	end
	dead_gap_a: assert property (@(posedge core_clk) disable iff (srst) // [RULE14]
		st_q.dead |-> $past(st_q.cnt) == LAST)
		else $error("clock loss flagged early");
endmodule // tsd_clk_mon

// File: src/tsd_dma_dir.sv
// One DMA direction: request, grant handshake, burst beats, overrun.
// Assumes the grant is synchronous and active low.
`timescale 1ns/1ns
module tsd_dma_dir
	import tsd_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// Request trigger
	input wire logic due,
	input wire logic [2:0] cnt,
	// Handshake
	input wire logic grant_n,
	output logic req_n,
	// Beats and error
	output logic take,
	output logic [1:0] take_idx,
	output logic ovr
);
	typedef struct packed {
		tsd_dir_st_t st;
		logic req_n;
		logic [2:0] left;
		logic [1:0] idx;
	} tsd_dir_q_t;
	localparam tsd_dir_q_t DIR_RST = '{DIR_IDLE, 1'b1, 3'h0, 2'h0};
	tsd_dir_q_t st_q, st_d;
	logic [2:0] lim;
	assign lim = (cnt > MAX_BURST) ? MAX_BURST : cnt; // [RULE9]
	assign take = (st_q.st == DIR_BUSY) & !grant_n; // [RULE7]
	assign take_idx = st_q.idx;
	assign ovr = due & (st_q.st == DIR_BUSY); // [RULE12]
	assign req_n = st_q.req_n;
	always_comb
	begin
		st_d = st_q;
		case (st_q.st)
			DIR_IDLE: st_d.req_n = 1'b1;
			DIR_BUSY:
			begin
				if (take)
				begin
					st_d.left = st_q.left - 3'h1;
					st_d.idx = st_q.idx + 2'h1;
					if (st_q.left == 3'h1) // [RULE8]
					begin
						st_d.st = DIR_IDLE;
						st_d.req_n = 1'b1;
					end
				end
			end
			default: st_d = DIR_RST;
		endcase
		if (due && lim != 3'h0) // [RULE7]
		begin
			st_d.st = DIR_BUSY;
			st_d.req_n = 1'b0;
			st_d.left = lim;
			st_d.idx = 2'h0;
		end
	end
	always_ff @(posedge core_clk)
	begin
		if (srst)
			st_q <= DIR_RST;
		else
			st_q <= st_d;
	end
	burst_len_a: assert property (@(posedge core_clk) disable iff (srst) // [RULE9]
		st_q.left <= MAX_BURST)
		else $error("burst longer than four bytes");
	req_busy_a: assert property (@(posedge core_clk) disable iff (srst) // [RULE8]
		(st_q.st == DIR_BUSY) == !req_n)
		else $error("request not low for whole burst");
	last_beat_a: assert property (@(posedge core_clk) disable iff (srst) // [RULE7]
		(take && st_q.left == 3'h1 && !due) |=> req_n)
		else $error("request held after last beat");
endmodule // tsd_dma_dir

// File: src/tsd_host_dma.sv
// Host registers, indirect window and DMA engine of the switch.
// Assumes switch core gives slot pulses, CE-based counts and memories.
// Overview of operation
// RULE1: DMA only in strobe-style latch-enable bus modes
// RULE2: DMA gate takes effect at next frame
// RULE3: Software marks channels before setting DMA gate
// RULE4: One select bit enables both directions
// RULE5: Slot zero skipped in first enabled frame
// RULE6: Pair one reads out, pair zero writes in
// RULE7: Request, await grant, one burst per slot
// RULE8: Read request at slot start, low whole burst
// RULE9: At most four bytes per burst
// RULE10: Write request at slot end
// RULE11: Write data lands one request later
// RULE12: Missed request sets overrun flag and error
// RULE13: Lock loss sets bit 7 until cleared
// RULE14: Dead backplane clock 4 ms sets bit 4
// RULE15: Overrun flags stay until zero written
// RULE16: Bit 3 drives backplane clocks as master
// RULE17: Bit 1 clear tristates bus, idles local
// RULE18: Bit 0 clears control space, keeps memories
// RULE19: Pointer is address-mode bit 0 plus low byte
// RULE20: Mode bits 7:6 pick auto-increment cases
// RULE21: Mode bits 5:4 pick target space
// RULE22: Window write stores byte, connection bytes alternate
// RULE23: Increment only in data or connection high
// RULE24: Registers fast, memory accesses wait for done
// RULE25: Latch-enable pin selects host bus style
// RULE26: Writing one keeps flags; error follows flags
`timescale 1ns/1ns
module tsd_host_dma
	import tsd_pkg::*;
#(
	parameter int DEAD_CYC = BP_DEAD_CYC
)
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// Host port
	input wire logic hp_cs_n,
	input wire logic hp_rd_n,
	input wire logic hp_wr_n,
	input wire logic hp_ale,
	input wire logic [1:0] hp_addr,
	input wire logic [7:0] hp_ad_in,
	output logic [7:0] hp_ad_out,
	output logic hp_ad_oe,
	output logic hp_rdy,
	// Memory port
	output tsd_mem_req_t mem_o,
	input wire logic [7:0] mem_rdata,
	input wire logic mem_done,
	// Switch core timing and data
	input tsd_ts_t ts_i,
	input wire logic [3:0][7:0] rd_bytes,
	output tsd_wr_out_t wr_o,
	output logic dma_active,
	// DMA handshake
	output logic [1:0] xfer_request_line_n,
	input wire logic [1:0] xfer_grant_line_n,
	// Status inputs
	input wire logic pll_unlock,
	input wire logic backplane_4mhz_clock,
	// Backplane and local outputs
	input wire logic ls_even_in,
	input wire logic ls_odd_in,
	output logic err_pin,
	output logic bus_timing_master,
	output logic stream_drive_enable,
	output logic bp_out_oe,
	output logic bp_clk_oe,
	output logic local_serial_out_even,
	output logic local_serial_out_odd,
	output logic [CTRL_N-1:0][7:0] cfg_o
);
	////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic [7:0] master_control_status;
		logic [7:0] indirect_pointer_low;
		logic [7:0] pointer_mode_select;
		logic [CTRL_N-1:0][7:0] cfg;
		logic bus_mux;
		logic ale;
		logic ale_ok;
		logic strb;
		logic busy;
		logic rd_mem;
		logic [1:0] lat;
		logic [7:0] ad_out;
		logic ad_oe;
		logic rdy;
		tsd_mem_req_t mem;
		logic dma_on;
		logic first;
		logic [3:0][7:0] hold;
		logic [2:0] hold_cnt;
		tsd_wr_out_t wr;
		logic err;
		logic mst;
		logic drv;
		logic bp_oe;
		logic bp_clk_oe;
		logic ls_even;
		logic ls_odd;
	} tsd_top_q_t;
	localparam tsd_top_q_t TOP_RST = '{rdy: 1'b1, ls_even: 1'b1, default: '0};
	tsd_top_q_t st_q, st_d;
	tsd_bus_mode_t mode;
	logic [1:0] addr;
	logic is_wr, strb, start, inc_en, dma_ok;
	logic [1:0] space;
	logic [8:0] ptr, ptr_nx;
	logic rd_due, wr_due;
	logic rd_take, wr_take, rd_ovr, wr_ovr, clk_dead;
	logic [1:0] rd_idx, wr_idx;
	////////////////////////////////////////////////////////////////////////
	// Host cycle decode
	assign mode = st_q.bus_mux ? BUS_MUX
		: (hp_ale ? BUS_DSRW : BUS_STROBE); // [RULE25]
	assign addr = (mode == BUS_MUX) ? st_q.lat : hp_addr;
	assign is_wr = !hp_wr_n;
	assign strb = !hp_cs_n
		& ((mode == BUS_DSRW) ? !hp_rd_n : (!hp_rd_n | !hp_wr_n));
	assign start = strb & !st_q.strb & !st_q.busy;
	assign space = st_q.pointer_mode_select[AMR_SP_HI:AMR_SP_LO]; // [RULE21]
	assign ptr = {st_q.pointer_mode_select[AMR_A8], st_q.indirect_pointer_low}; // [RULE19]
	assign ptr_nx = ptr + PTR_STEP;
	assign inc_en = is_wr ? st_q.pointer_mode_select[AMR_INC_WR]
		: st_q.pointer_mode_select[AMR_INC_RD]; // [RULE20]
	assign dma_ok = (mode != BUS_DSRW); // [RULE1]
	////////////////////////////////////////////////////////////////////////
	// DMA request timing
	assign rd_due = st_q.dma_on & ts_i.ts_start & ts_i.dma_any
		& !(st_q.first & (ts_i.idx == TS_ZERO)); // [RULE4] [RULE5] [RULE8]
	assign wr_due = st_q.dma_on & ts_i.ts_end & ts_i.dma_any
		& !(st_q.first & (ts_i.idx == TS_ZERO)); // [RULE4] [RULE5] [RULE10]
	tsd_dma_dir u_rd (
		.core_clk(core_clk),
		.srst(srst),
		.due(rd_due),
		.cnt(ts_i.dma_cnt),
		.grant_n(xfer_grant_line_n[DIR_RD]),
		.req_n(xfer_request_line_n[DIR_RD]),
		.take(rd_take),
		.take_idx(rd_idx),
		.ovr(rd_ovr)
	); // [RULE6]
	tsd_dma_dir u_wr (
		.core_clk(core_clk),
		.srst(srst),
		.due(wr_due),
		.cnt(ts_i.dma_cnt),
		.grant_n(xfer_grant_line_n[DIR_WR]),
		.req_n(xfer_request_line_n[DIR_WR]),
		.take(wr_take),
		.take_idx(wr_idx),
		.ovr(wr_ovr)
	); // [RULE6]
	tsd_clk_mon #(
		.DEAD_CYC(DEAD_CYC)
	) u_mon (
		.core_clk(core_clk),
		.srst(srst),
		.clk_in(backplane_4mhz_clock),
		.dead(clk_dead)
	);
	////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		st_d = st_q;
		st_d.wr.valid = 1'b0;
		// Bus style tracking
		st_d.ale = hp_ale;
		st_d.ale_ok = 1'b1;
		if (st_q.ale_ok && hp_ale != st_q.ale)
			st_d.bus_mux = 1'b1; // [RULE25]
		if (mode == BUS_MUX && hp_ale)
			st_d.lat = hp_ad_in[1:0];
		st_d.strb = strb;
		// Soft reset of control space
		if (st_q.master_control_status[MCS_SRST]) // [RULE18]
		begin
			st_d.master_control_status = st_q.master_control_status & MCS_KEEP_SRST;
			st_d.indirect_pointer_low = REG_RST;
			st_d.pointer_mode_select = REG_RST;
			st_d.cfg = '0;
		end
		// Host access start
		if (start)
		begin
			case (addr)
				REG_MCS:
				begin
					if (is_wr) // [RULE26]
						st_d.master_control_status = (st_d.master_control_status & hp_ad_in & MCS_STICKY)
							| (hp_ad_in & MCS_CTRL);
					else
						st_d.ad_out = st_q.master_control_status;
				end
				REG_LAR:
				begin
					if (is_wr)
						st_d.indirect_pointer_low = hp_ad_in;
					else
						st_d.ad_out = st_q.indirect_pointer_low;
				end
				REG_AMR:
				begin
					if (is_wr)
						st_d.pointer_mode_select = hp_ad_in;
					else
						st_d.ad_out = st_q.pointer_mode_select;
				end
				REG_IDR:
				begin
					if (space == SP_CTRL)
					begin
						if (ptr < CTRL_LIM && is_wr) // [RULE22]
							st_d.cfg[ptr[3:0]] = hp_ad_in;
						else if (ptr < CTRL_LIM)
							st_d.ad_out = st_q.cfg[ptr[3:0]];
						else
							st_d.ad_out = REG_RST;
					end
					else
					begin
						st_d.mem.req = 1'b1;
						st_d.mem.we = is_wr;
						st_d.mem.space = space;
						st_d.mem.addr = ptr;
						st_d.mem.wdata = hp_ad_in; // [RULE22]
						st_d.busy = 1'b1;
						st_d.rdy = 1'b0; // [RULE24]
						st_d.rd_mem = !is_wr;
					end
					if (space == SP_DMEM && inc_en) // [RULE23]
					begin
						st_d.indirect_pointer_low = ptr_nx[7:0];
						st_d.pointer_mode_select[AMR_A8] = ptr_nx[8];
					end
					else if (space == SP_CM_LO) // [RULE22]
						st_d.pointer_mode_select[AMR_SP_HI:AMR_SP_LO] = SP_CM_HI;
					else if (space == SP_CM_HI && inc_en) // [RULE23]
					begin
						st_d.pointer_mode_select[AMR_SP_HI:AMR_SP_LO] = SP_CM_LO;
						st_d.indirect_pointer_low = ptr_nx[7:0];
						st_d.pointer_mode_select[AMR_A8] = ptr_nx[8];
					end
				end
				default: st_d.ad_out = REG_RST;
			endcase
		end
		// Memory completion
		if (st_q.busy && mem_done) // [RULE24]
		begin
			st_d.busy = 1'b0;
			st_d.mem.req = 1'b0;
			st_d.rdy = 1'b1;
			if (st_q.rd_mem)
				st_d.ad_out = mem_rdata;
		end
		// DMA gate, on from frame start, off at once
		if (!st_q.master_control_status[MCS_DMA] || !dma_ok) // [RULE1]
		begin
			st_d.dma_on = 1'b0;
			st_d.first = 1'b0;
		end
		else if (ts_i.frame_start) // [RULE2]
		begin
			st_d.dma_on = 1'b1;
			st_d.first = !st_q.dma_on; // [RULE5]
		end
		// DMA read beats onto the host bus
		if (rd_take)
			st_d.ad_out = rd_bytes[rd_idx];
		st_d.ad_oe = (strb & !is_wr) | rd_take;
		// DMA write beats held for the next request
		if (wr_take)
		begin
			st_d.hold[wr_idx] = hp_ad_in;
			st_d.hold_cnt = {1'b0, wr_idx} + 3'h1;
		end
		if (wr_due) // [RULE11]
		begin
			st_d.wr.valid = (st_q.hold_cnt != 3'h0);
			st_d.wr.ts = ts_i.idx;
			st_d.wr.cnt = st_q.hold_cnt;
			st_d.wr.bytes = st_q.hold;
			st_d.hold_cnt = 3'h0;
		end
		// Sticky flags, set wins over clear
		if (pll_unlock)
			st_d.master_control_status[MCS_LOCK] = 1'b1; // [RULE13]
		if (wr_ovr)
			st_d.master_control_status[MCS_WOV] = 1'b1; // [RULE12] [RULE15]
		if (rd_ovr)
			st_d.master_control_status[MCS_ROV] = 1'b1; // [RULE12] [RULE15]
		if (clk_dead)
			st_d.master_control_status[MCS_CLKE] = 1'b1; // [RULE14]
		// Pin outputs from the new control value
		st_d.err = |(st_d.master_control_status & MCS_STICKY); // [RULE26]
		st_d.mst = st_d.master_control_status[MCS_MST]; // [RULE16]
		st_d.drv = st_d.master_control_status[MCS_EN];
		st_d.bp_oe = st_d.master_control_status[MCS_EN]; // [RULE17]
		st_d.bp_clk_oe = st_d.master_control_status[MCS_EN] & st_d.master_control_status[MCS_MST]; // [RULE16]
		st_d.ls_even = st_d.master_control_status[MCS_EN] ? ls_even_in : 1'b1; // [RULE17]
		st_d.ls_odd = st_d.master_control_status[MCS_EN] & ls_odd_in; // [RULE17]
	end
	always_ff @(posedge core_clk)
	begin
		if (srst)
			st_q <= TOP_RST;
		else
			st_q <= st_d;
	end
	////////////////////////////////////////////////////////////////////////
	// Output drive
	assign hp_ad_out = st_q.ad_out;
	assign hp_ad_oe = st_q.ad_oe;
	assign hp_rdy = st_q.rdy;
	assign mem_o = st_q.mem;
	assign wr_o = st_q.wr;
	assign dma_active = st_q.dma_on;
	assign err_pin = st_q.err;
	assign bus_timing_master = st_q.mst;
	assign stream_drive_enable = st_q.drv;
	assign bp_out_oe = st_q.bp_oe;
	assign bp_clk_oe = st_q.bp_clk_oe;
	assign local_serial_out_even = st_q.ls_even;
	assign local_serial_out_odd = st_q.ls_odd;
	assign cfg_o = st_q.cfg;
	////////////////////////////////////////////////////////////////////////
	// Checks
	gate_frame_a: assert property (@(posedge core_clk) disable iff (srst) // [RULE2]
		$rose(st_q.dma_on) |-> $past(ts_i.frame_start))
		else $error("DMA started off frame boundary");
	dsrw_nodma_a: assert property (@(posedge core_clk) disable iff (srst) // [RULE1]
		(mode == BUS_DSRW) |=> !st_q.dma_on)
		else $error("DMA active in strobe/rw mode");
	ts0_skip_a: assert property (@(posedge core_clk) disable iff (srst) // [RULE5]
		(st_q.dma_on && st_q.first && ts_i.ts_start
		&& ts_i.idx == TS_ZERO && xfer_request_line_n[DIR_RD])
		|=> xfer_request_line_n[DIR_RD])
		else $error("slot zero requested in first frame");
	rd_start_a: assert property (@(posedge core_clk) disable iff (srst) // [RULE8]
		(st_q.dma_on && !st_q.first && ts_i.ts_start && ts_i.dma_any)
		|=> !xfer_request_line_n[DIR_RD])
		else $error("read request missing at slot start");
	wr_end_a: assert property (@(posedge core_clk) disable iff (srst) // [RULE10]
		(st_q.dma_on && !st_q.first && ts_i.ts_end && ts_i.dma_any)
		|=> !xfer_request_line_n[DIR_WR])
		else $error("write request missing at slot end");
	ovr_flag_a: assert property (@(posedge core_clk) disable iff (srst) // [RULE12]
		(wr_ovr || rd_ovr) |=> ##1 err_pin)
		else $error("overrun did not raise error pin");
	lock_flag_a: assert property (@(posedge core_clk) disable iff (srst) // [RULE13]
		pll_unlock |=> st_q.master_control_status[MCS_LOCK] && err_pin)
		else $error("lock loss not flagged");
	err_track_a: assert property (@(posedge core_clk) disable iff (srst) // [RULE26]
		err_pin == |(st_q.master_control_status & MCS_STICKY))
		else $error("error pin disagrees with flags");
	idle_out_a: assert property (@(posedge core_clk) disable iff (srst) // [RULE17]
		!st_q.master_control_status[MCS_EN] |-> (local_serial_out_even
		&& !local_serial_out_odd && !bp_out_oe && !bp_clk_oe))
		else $error("outputs not idle while disabled");
	fast_reg_a: assert property (@(posedge core_clk) disable iff (srst) // [RULE24]
		(start && addr != REG_IDR) |=> hp_rdy)
		else $error("register access inserted wait");
	cm_toggle_a: assert property (@(posedge core_clk) disable iff (srst) // [RULE22]
		(start && addr == REG_IDR && space == SP_CM_LO
		&& !st_q.master_control_status[MCS_SRST])
		|=> st_q.pointer_mode_select[AMR_SP_HI:AMR_SP_LO] == SP_CM_HI)
		else $error("connection byte did not toggle");
	rd_burst_c: cover property (@(posedge core_clk) disable iff (srst)
		!xfer_request_line_n[DIR_RD] ##1 rd_take [*4] ##1
		xfer_request_line_n[DIR_RD]);
	ovr_c: cover property (@(posedge core_clk) disable iff (srst)
		wr_ovr);
	cm_wrap_c: cover property (@(posedge core_clk) disable iff (srst)
		start && addr == REG_IDR && space == SP_CM_HI && inc_en);
endmodule // tsd_host_dma

// File: src/tsd_pkg.sv
// Shared constants, modes and carriers of the switch host block.
// Assumes one 20 MHz core clock and timing pulses from the switch core.
package tsd_pkg;
	// Direct register offsets
	localparam logic [1:0] REG_MCS = 2'h0;
	localparam logic [1:0] REG_LAR = 2'h1;
	localparam logic [1:0] REG_AMR = 2'h2;
	localparam logic [1:0] REG_IDR = 2'h3;
	// Master control/status fields
	localparam int MCS_LOCK = 7;
	localparam int MCS_WOV = 6;
	localparam int MCS_ROV = 5;
	localparam int MCS_CLKE = 4;
	localparam int MCS_MST = 3;
	localparam int MCS_DMA = 2;
	localparam int MCS_EN = 1;
	localparam int MCS_SRST = 0;
	localparam logic [7:0] MCS_STICKY = 8'hF0;
	localparam logic [7:0] MCS_CTRL = 8'h0F;
	localparam logic [7:0] MCS_KEEP_SRST = 8'h01;
	localparam logic [7:0] REG_RST = 8'h00;
	// Pointer mode fields
	localparam int AMR_INC_WR = 7;
	localparam int AMR_INC_RD = 6;
	localparam int AMR_SP_HI = 5;
	localparam int AMR_SP_LO = 4;
	localparam int AMR_A8 = 0;
	localparam logic [1:0] SP_CTRL = 2'h0;
	localparam logic [1:0] SP_DMEM = 2'h1;
	localparam logic [1:0] SP_CM_LO = 2'h2;
	localparam logic [1:0] SP_CM_HI = 2'h3;
	// Control space and DMA limits
	localparam int CTRL_N = 16;
	localparam logic [8:0] CTRL_LIM = 9'h010;
	localparam logic [8:0] PTR_STEP = 9'h001;
	localparam logic [2:0] MAX_BURST = 3'h4;
	localparam logic [4:0] TS_ZERO = 5'h00;
	localparam int DIR_WR = 0;
	localparam int DIR_RD = 1;
	// Timing
	localparam int CLK_HZ = 20000000;
	localparam int BP_DEAD_US = 4000;
	localparam int BP_DEAD_CYC = BP_DEAD_US * (CLK_HZ / 1000000);
	typedef enum logic [1:0] {BUS_STROBE, BUS_DSRW, BUS_MUX} tsd_bus_mode_t;
	typedef enum logic {DIR_IDLE, DIR_BUSY} tsd_dir_st_t;
	typedef struct packed {
		logic frame_start;
		logic ts_start;
		logic ts_end;
		logic [4:0] idx;
		logic dma_any;
		logic [2:0] dma_cnt;
	} tsd_ts_t;
	typedef struct packed {
		logic req;
		logic we;
		logic [1:0] space;
		logic [8:0] addr;
		logic [7:0] wdata;
	} tsd_mem_req_t;
	typedef struct packed {
		logic valid;
		logic [4:0] ts;
		logic [2:0] cnt;
		logic [3:0][7:0] bytes;
	} tsd_wr_out_t;
endpackage
